// File: pia_regs.svh
`ifndef PIA_REGS_SVH
`define PIA_REGS_SVH

// register offsets on the local register port
`define PIA_OFS_PRI_LO 8'h84
`define PIA_OFS_PRI_HI 8'h86
`define PIA_OFS_DMA_TMR 8'h88
`define PIA_OFS_TMR_SER 8'h8a
`define PIA_OFS_MISC 8'h8c
`define PIA_OFS_CTRL 8'h8e

// reset values
`define PIA_PRI_RST 16'h0000
`define PIA_SENSE_RST 8'h00

// control register field positions
`define PIA_CTRL_NMI_LVL 15
`define PIA_CTRL_NMI_EDGE 8

// fixed levels and mask loads
`define PIA_LVL_NMI 5'h10
`define PIA_LVL_BRK 5'h0f
`define PIA_MASK_FIXED 4'hf

// vector numbers
`define PIA_VEC_NMI 8'h0b
`define PIA_VEC_BRK 8'h0c
`define PIA_VEC_PIN0 8'h40
`define PIA_VEC_DMA0 8'h48
`define PIA_VEC_TMR0 8'h50
`define PIA_DMA_STRIDE 2
`define PIA_TMR_STRIDE 4

`endif

// File: pia_pkg.sv
package pia_pkg;

  typedef logic [4:0] pia_level_t;
  typedef logic [7:0] pia_vec_t;

  // source class, one-hot
  typedef enum logic [3:0] {
    PIA_CLS_NMI = 4'b0001,
    PIA_CLS_BRK = 4'b0010,
    PIA_CLS_PIN = 4'b0100,
    PIA_CLS_CHIP = 4'b1000
  } pia_class_t;

endpackage

// File: pia_arbiter.sv
`timescale 1ns/1ps
`include "pia_regs.svh"

// Operation
// RULE1: rank levels 0 to 16, larger wins, 16 highest
// RULE2: maskable source at level 0 never reaches the cpu
// RULE3: non-maskable request is level 16 and always accepted
// RULE4: non-maskable pin edge sensed, control bit picks rising or falling
// RULE5: non-maskable acceptance loads mask level 15
// RULE6: debug break request raised on break match, fixed level 15
// RULE7: debug break acceptance loads mask level 15
// RULE8: each request pin picks low-level or falling-edge sensing alone
// RULE9: pins 0-7 take 4-bit priority fields in two priority registers
// RULE10: pin acceptance loads that pin's priority as mask
// RULE11: every on-chip source has its own vector
// RULE12: dma and timer priorities come from third and fourth registers
// RULE13: on-chip acceptance loads that module's priority as mask
// RULE14: sources sharing a field ranked by fixed in-module order
// RULE15: reset clears every priority field to level 0
// RULE16: equal levels resolved by fixed default order
// RULE17: vectors: nmi 11, break 12, pins 64-71, dma 72-78 even
// RULE18: timers 0-2 use vector groups at 80, 84, 88
// RULE19: vector table offset is four times the vector number
// RULE20: control msb shows the non-maskable pin level
// RULE21: request-out pin flags a pending on-chip source; code drives it low only while an on-chip source is the forwarded winner
// RULE22: maskable winner forwarded only when above cpu mask level
// RULE23: resolution combinational, answer registered within one cycle
module pia_arbiter
  import pia_pkg::*;
#(
  parameter int NUM_PIN = 8,
  parameter int NUM_DMA = 4,
  parameter int NUM_TMR = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // request sources
  input wire logic nmi_pin,
  input wire logic debug_break_unit,
  input wire logic [NUM_PIN-1:0] irq_n,
  input wire logic [NUM_DMA-1:0] dma_end,
  input wire logic [NUM_TMR-1:0] timer_compare_a,
  input wire logic [NUM_TMR-1:0] timer_compare_b,
  input wire logic [NUM_TMR-1:0] timer_overflow,
  // cpu side
  input wire logic [3:0] cpu_mask_level,
  input wire logic cpu_ack,
  output logic int_req,
  output pia_vec_t int_vector,
  output logic [3:0] int_level,
  output logic [9:0] int_vec_offset,
  // request-out pin, active low
  output logic request_out_n
);

  localparam int NSRC = 2 + NUM_PIN + NUM_DMA + 3 * NUM_TMR;
  localparam int FDMA = 2 + NUM_PIN;
  localparam int FTMR = FDMA + NUM_DMA;

  // the field layout is fixed, so only the documented counts fit
  if (NUM_PIN != 8 || NUM_DMA != 4 || NUM_TMR != 3) begin : g_bad
    $error("pia_arbiter: source counts must be 8, 4 and 3");
  end

  // 4-bit field n of a 16-bit priority register, n=0 is bits 15-12
  function automatic logic [3:0] fld(input logic [15:0] r, input int n);
    fld = r[15 - 4 * n -: 4];
  endfunction

  // mask level loaded on acceptance
  function automatic logic [3:0] mask_of(input pia_class_t c, input pia_level_t l);
    case (c)
      PIA_CLS_NMI: mask_of = `PIA_MASK_FIXED;
      PIA_CLS_BRK: mask_of = `PIA_MASK_FIXED;
      default: mask_of = l[3:0];
    endcase
  endfunction

  logic [15:0] external_pin_priority_lo;
  logic [15:0] external_pin_priority_hi;
  logic [15:0] dma_timer_priority;
  logic [15:0] timer_serial_priority;
  logic [15:0] misc_module_priority;
  logic nmi_edge_select;
  logic [NUM_PIN-1:0] pin_sense_select;
  logic nmi_prev;
  logic nmi_pend;
  logic brk_pend;
  logic [NUM_PIN-1:0] irq_prev;
  logic [NUM_PIN-1:0] irq_latch;
  logic [4:0] win_idx;
  logic nmi_edge;
  logic [NSRC-1:0] src_pend;
  logic [NSRC-1:0] src_live;
  logic [NSRC-1:0] src_fwd;
  logic [NSRC-1:0] ack_hit;
  pia_level_t src_lvl [NSRC];
  pia_vec_t src_vec [NSRC];
  pia_class_t src_cls [NSRC];
  logic best_ok;
  logic [4:0] best_idx;
  pia_level_t best_lvl;
  logic [15:0] ctrl_view;

  // register writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      external_pin_priority_lo <= `PIA_PRI_RST; // [RULE15]
      external_pin_priority_hi <= `PIA_PRI_RST;
      dma_timer_priority <= `PIA_PRI_RST;
      timer_serial_priority <= `PIA_PRI_RST;
      misc_module_priority <= `PIA_PRI_RST;
      nmi_edge_select <= 1'b0;
      pin_sense_select <= `PIA_SENSE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `PIA_OFS_PRI_LO: external_pin_priority_lo <= reg_wdata;
        `PIA_OFS_PRI_HI: external_pin_priority_hi <= reg_wdata;
        `PIA_OFS_DMA_TMR: dma_timer_priority <= reg_wdata;
        `PIA_OFS_TMR_SER: timer_serial_priority <= reg_wdata;
        `PIA_OFS_MISC: misc_module_priority <= reg_wdata;
        `PIA_OFS_CTRL: begin
          nmi_edge_select <= reg_wdata[`PIA_CTRL_NMI_EDGE]; // [RULE4]
          pin_sense_select <= reg_wdata[NUM_PIN-1:0]; // [RULE8]
        end
        default: ;
      endcase
    end
  end

  // control register view, msb follows the pin
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[`PIA_CTRL_NMI_LVL] = nmi_prev; // [RULE20]
    ctrl_view[`PIA_CTRL_NMI_EDGE] = nmi_edge_select;
    ctrl_view[NUM_PIN-1:0] = pin_sense_select;
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PIA_OFS_PRI_LO: reg_rdata <= external_pin_priority_lo;
        `PIA_OFS_PRI_HI: reg_rdata <= external_pin_priority_hi;
        `PIA_OFS_DMA_TMR: reg_rdata <= dma_timer_priority;
        `PIA_OFS_TMR_SER: reg_rdata <= timer_serial_priority;
        `PIA_OFS_MISC: reg_rdata <= misc_module_priority;
        `PIA_OFS_CTRL: reg_rdata <= ctrl_view;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // acknowledge hits the source presented last cycle
  always_comb begin
    ack_hit = '0;
    if (cpu_ack && int_req) begin
      ack_hit[win_idx] = 1'b1;
    end
  end

  // non-maskable edge, polarity chosen by software
  assign nmi_edge = nmi_edge_select ? (nmi_pin & ~nmi_prev) : (~nmi_pin & nmi_prev); // [RULE4]

  // previous pin levels for edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_prev <= 1'b0;
      irq_prev <= '1;
    end else begin
      nmi_prev <= nmi_pin;
      irq_prev <= irq_n;
    end
  end

  // non-maskable and break latches, a new event beats the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_pend <= 1'b0;
      brk_pend <= 1'b0;
    end else begin
      if (nmi_edge) begin
        nmi_pend <= 1'b1; // [RULE3]
      end else if (ack_hit[0]) begin
        nmi_pend <= 1'b0;
      end
      if (debug_break_unit) begin
        brk_pend <= 1'b1; // [RULE6]
      end else if (ack_hit[1]) begin
        brk_pend <= 1'b0;
      end
    end
  end

  // falling-edge latches for pins in edge mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_latch <= '0;
    end else begin
      for (int i = 0; i < NUM_PIN; i++) begin
        if (!pin_sense_select[i]) begin
          irq_latch[i] <= 1'b0;
        end else if (irq_prev[i] && !irq_n[i]) begin
          irq_latch[i] <= 1'b1; // [RULE8]
        end else if (ack_hit[2 + i]) begin
          irq_latch[i] <= 1'b0;
        end
      end
    end
  end

  // source table in default order: levels, vectors, classes
  always_comb begin
    src_pend = '0;
    for (int i = 0; i < NSRC; i++) begin
      src_lvl[i] = 5'h00;
      src_vec[i] = 8'h00;
      src_cls[i] = PIA_CLS_CHIP;
    end
    src_pend[0] = nmi_pend;
    src_lvl[0] = `PIA_LVL_NMI; // [RULE3]
    src_vec[0] = `PIA_VEC_NMI; // [RULE17]
    src_cls[0] = PIA_CLS_NMI;
    src_pend[1] = brk_pend;
    src_lvl[1] = `PIA_LVL_BRK; // [RULE6]
    src_vec[1] = `PIA_VEC_BRK;
    src_cls[1] = PIA_CLS_BRK;
    for (int i = 0; i < NUM_PIN; i++) begin
      src_pend[2 + i] = pin_sense_select[i] ? irq_latch[i] : ~irq_n[i]; // [RULE8]
      src_lvl[2 + i] = {1'b0, (i < 4) ? fld(external_pin_priority_lo, i)
                                      : fld(external_pin_priority_hi, i - 4)}; // [RULE9]
      src_vec[2 + i] = `PIA_VEC_PIN0 + 8'(i);
      src_cls[2 + i] = PIA_CLS_PIN;
    end
    // channels 0,1 share one field, 2,3 the next; lower channel ranks first
    for (int i = 0; i < NUM_DMA; i++) begin
      src_pend[FDMA + i] = dma_end[i];
      src_lvl[FDMA + i] = {1'b0, fld(dma_timer_priority, i / 2)}; // [RULE12] [RULE14]
      src_vec[FDMA + i] = `PIA_VEC_DMA0 + 8'(`PIA_DMA_STRIDE * i); // [RULE11]
    end
    // each timer: compare a, compare b, overflow in falling rank
    for (int t = 0; t < NUM_TMR; t++) begin
      for (int s = 0; s < 3; s++) begin
        src_pend[FTMR + 3 * t + s] = (s == 0) ? timer_compare_a[t] :
                                     (s == 1) ? timer_compare_b[t] : timer_overflow[t]; // [RULE14]
        src_lvl[FTMR + 3 * t + s] = {1'b0, (t < 2) ? fld(dma_timer_priority, 2 + t)
                                                  : fld(timer_serial_priority, 0)}; // [RULE12]
        src_vec[FTMR + 3 * t + s] = `PIA_VEC_TMR0 + 8'(`PIA_TMR_STRIDE * t + s); // [RULE18]
      end
    end
  end

  // a source still in flight of acknowledge is not offered again
  assign src_live = src_pend & ~ack_hit;

  // forwarding test against level 0 and the cpu mask
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      if (src_cls[i] == PIA_CLS_NMI) begin
        src_fwd[i] = 1'b1; // [RULE3]
      end else begin
        src_fwd[i] = (src_lvl[i] != 5'h00) && (src_lvl[i] > {1'b0, cpu_mask_level}); // [RULE2] [RULE22]
      end
    end
  end

  // combinational resolve; strict greater keeps the earlier source on ties
  always_comb begin
    best_ok = 1'b0;
    best_idx = 5'h00;
    best_lvl = 5'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (src_live[i] && src_fwd[i] && (!best_ok || src_lvl[i] > best_lvl)) begin // [RULE1] [RULE16]
        best_ok = 1'b1;
        best_idx = 5'(i);
        best_lvl = src_lvl[i];
      end
    end
  end

  // registered answer to the cpu
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_req <= 1'b0;
      int_vector <= 8'h00;
      int_level <= 4'h0;
      int_vec_offset <= 10'h000;
      win_idx <= 5'h00;
    end else begin
      int_req <= best_ok; // [RULE23]
      int_vector <= src_vec[best_idx];
      int_level <= mask_of(src_cls[best_idx], best_lvl); // [RULE5] [RULE7] [RULE10] [RULE13]
      int_vec_offset <= {src_vec[best_idx], 2'b00}; // [RULE19]
      win_idx <= best_idx;
    end
  end

  // request-out pin low while an on-chip source is offered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      request_out_n <= 1'b1;
    end else begin
      request_out_n <= ~(best_ok && src_cls[best_idx] == PIA_CLS_CHIP); // [RULE21]
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pin0_fall;
    pin_sense_select[0] && $fell(irq_n[0]);
  endsequence

  sequence s_pin0_held;
    irq_latch[0] ##1 irq_latch[0] || !pin_sense_select[0] || ack_hit[2];
  endsequence

  nmi_always_wins_a: assert property ( // [RULE3]
    nmi_pend && !ack_hit[0] |=> int_req && int_vector == `PIA_VEC_NMI)
    else $error("pending nmi not presented");

  nmi_rise_a: assert property ( // [RULE4]
    nmi_edge_select && $rose(nmi_pin) && !ack_hit[0] |=> nmi_pend)
    else $error("nmi rising edge missed");

  nmi_fall_a: assert property ( // [RULE4]
    !nmi_edge_select && $fell(nmi_pin) |=> nmi_pend ##1 int_req)
    else $error("nmi falling edge missed");

  fixed_mask_a: assert property ( // [RULE5]
    int_req && (int_vector == `PIA_VEC_NMI || int_vector == `PIA_VEC_BRK) |-> int_level == 4'hf)
    else $error("fixed source mask not 15");

  level_zero_a: assert property ( // [RULE2]
    int_req && int_vector != `PIA_VEC_NMI |-> int_level != 4'h0)
    else $error("level 0 source forwarded");

  above_mask_a: assert property ( // [RULE22]
    int_req && int_vector != `PIA_VEC_NMI |-> int_level > $past(cpu_mask_level))
    else $error("request not above cpu mask");

  pin_edge_a: assert property ( // [RULE8]
    s_pin0_fall |=> s_pin0_held)
    else $error("pin 0 falling edge not latched");

  nmi_vector_a: assert property ( // [RULE17]
    int_req && win_idx == 5'h00 |-> int_vector == `PIA_VEC_NMI)
    else $error("nmi vector wrong");

  table_offset_a: assert property ( // [RULE19]
    int_req |-> int_vec_offset == {int_vector, 2'b00})
    else $error("vector offset not four times vector");

  resolve_one_a: assert property ( // [RULE23]
    |(src_live & src_fwd) |=> int_req)
    else $error("request not presented next cycle");

  req_out_a: assert property ( // [RULE21]
    !request_out_n |-> int_req && int_vector >= `PIA_VEC_DMA0)
    else $error("request-out without on-chip source");

endmodule

// File: pia_cpu_model.sv
`timescale 1ns/1ps
module pia_cpu_model
  import pia_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // arbiter side
  input wire logic int_req,
  input wire logic [3:0] int_level,
  output logic cpu_ack,
  output logic [3:0] cpu_mask_level,
  // test control
  input wire logic ack_en,
  input wire logic [1:0] ack_wait,
  input wire logic [3:0] mask_set
);
  logic [1:0] wait_cnt;
  logic cool;
  // accept after ack_wait cycles; cool skips the stale request seen just after an ack
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      cool <= 1'b0;
      wait_cnt <= 2'h0;
      cpu_mask_level <= 4'h0;
    end else begin
      cpu_ack <= 1'b0;
      cool <= cpu_ack;
      wait_cnt <= 2'h0;
      if (!ack_en) begin
        cpu_mask_level <= mask_set;
      end else if (int_req && !cpu_ack && !cool) begin
        if (wait_cnt == ack_wait) begin
          cpu_ack <= 1'b1;
          cpu_mask_level <= int_level;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule

// File: priority_interrupt_arbiter_tb_top.sv
`timescale 1ns/1ps
module priority_interrupt_arbiter_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic nmi_pin = 1'b1;
  logic debug_break_unit = 1'b0;
  logic [7:0] irq_n = 8'hff;
  logic [3:0] dma_end = 4'h0;
  logic [2:0] timer_compare_a = 3'h0;
  logic [2:0] timer_compare_b = 3'h0;
  logic [2:0] timer_overflow = 3'h0;
  logic [3:0] cpu_mask_level;
  logic cpu_ack;
  logic int_req;
  logic [7:0] int_vector;
  logic [3:0] int_level;
  logic [9:0] int_vec_offset;
  logic request_out_n;
  logic ack_en = 1'b0;
  logic [1:0] ack_wait = 2'h0;
  logic [3:0] mask_set = 4'h0;
  int compares = 0;
  int miscompares = 0;

  pia_arbiter dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
    .debug_break_unit(debug_break_unit), .irq_n(irq_n), .dma_end(dma_end),
    .timer_compare_a(timer_compare_a), .timer_compare_b(timer_compare_b), .timer_overflow(timer_overflow),
    .cpu_mask_level(cpu_mask_level), .cpu_ack(cpu_ack), .int_req(int_req), .int_vector(int_vector),
    .int_level(int_level), .int_vec_offset(int_vec_offset), .request_out_n(request_out_n));
  pia_cpu_model cpu_u (.clk_sys(clk_sys), .rst(rst), .int_req(int_req), .int_level(int_level),
    .cpu_ack(cpu_ack), .cpu_mask_level(cpu_mask_level), .ack_en(ack_en), .ack_wait(ack_wait),
    .mask_set(mask_set));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic r, input logic [7:0] v, input logic [3:0] l, input logic o);
    cmp({22'h0, int_req, request_out_n}, {22'h0, r, o});
    if (r)
      cmp({2'h0, int_vector, int_level, int_vec_offset}, {2'h0, v, l, v, 2'b00});
    // step to the next edge so that the caller drives right after it
    @(posedge clk_sys);
  endtask

  // cpu accepts the latched request, loads mask m, then is released
  task automatic take(input logic [3:0] m);
    @(posedge clk_sys);
    ack_en <= 1'b1;
    repeat (7) @(posedge clk_sys);
    #1;
    cmp({20'h0, cpu_mask_level}, {20'h0, m});
    chk(1'b0, 8'h00, 4'h0, 1'b1);
    @(posedge clk_sys);
    ack_en <= 1'b0;
  endtask

  task automatic t_regs;
    rd(8'h84, 16'h0000);
    rd(8'h86, 16'h0000);
    rd(8'h88, 16'h0000);
    rd(8'h8a, 16'h0000);
    rd(8'h8e, 16'h8000);
    wr(8'h8c, 16'h1234);
    rd(8'h8c, 16'h1234);
    wr(8'h90, 16'hffff);
    rd(8'h90, 16'h0000);
  endtask

  task automatic t_nmi;
    @(posedge clk_sys);
    ack_wait <= 2'h2;
    nmi_pin <= 1'b0;
    settle();
    chk(1'b1, 8'h0b, 4'hf, 1'b1);
    take(4'hf);
    wr(8'h8e, 16'h0100);
    rd(8'h8e, 16'h0100);
    @(posedge clk_sys);
    mask_set <= 4'hf;
    nmi_pin <= 1'b1;
    settle();
    chk(1'b1, 8'h0b, 4'hf, 1'b1);
    take(4'hf);
    ack_wait <= 2'h0;
    mask_set <= 4'h0;
  endtask

  task automatic t_brk;
    @(posedge clk_sys);
    debug_break_unit <= 1'b1;
    @(posedge clk_sys);
    debug_break_unit <= 1'b0;
    settle();
    chk(1'b1, 8'h0c, 4'hf, 1'b1);
    take(4'hf);
  endtask

  task automatic t_pin;
    wr(8'h84, 16'h5000);
    irq_n <= 8'hfe;
    settle();
    chk(1'b1, 8'h40, 4'h5, 1'b1);
    mask_set <= 4'h5;
    settle();
    chk(1'b0, 8'h00, 4'h0, 1'b1);
    mask_set <= 4'h4;
    settle();
    chk(1'b1, 8'h40, 4'h5, 1'b1);
    mask_set <= 4'h0;
    wr(8'h86, 16'h5000);
    irq_n <= 8'hee;
    settle();
    chk(1'b1, 8'h40, 4'h5, 1'b1);
    wr(8'h86, 16'h7000);
    settle();
    chk(1'b1, 8'h44, 4'h7, 1'b1);
    irq_n <= 8'hfd;
    settle();
    chk(1'b0, 8'h00, 4'h0, 1'b1);
    wr(8'h84, 16'h9000);
    wr(8'h8e, 16'h0101);
    irq_n <= 8'hfe;
    @(posedge clk_sys);
    irq_n <= 8'hff;
    settle();
    chk(1'b1, 8'h40, 4'h9, 1'b1);
    take(4'h9);
  endtask

  // reset in mid-run clears the priority fields read back at 84, 88, 8a and the control bits
  task automatic t_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(1'b0, 8'h00, 4'h0, 1'b1);
    rst <= 1'b0;
    rd(8'h88, 16'h0000);
    rd(8'h8a, 16'h0000);
    rd(8'h84, 16'h0000);
    rd(8'h8e, 16'h8000);
  endtask

  task automatic t_chip;
    wr(8'h88, 16'h3021);
    wr(8'h8a, 16'h4000);
    dma_end <= 4'h2;
    settle();
    chk(1'b1, 8'h4a, 4'h3, 1'b0);
    dma_end <= 4'h3;
    settle();
    chk(1'b1, 8'h48, 4'h3, 1'b0);
    dma_end <= 4'h4;
    settle();
    chk(1'b0, 8'h00, 4'h0, 1'b1);
    dma_end <= 4'h0;
    timer_compare_b <= 3'h1;
    timer_overflow <= 3'h3;
    settle();
    chk(1'b1, 8'h51, 4'h2, 1'b0);
    timer_compare_a <= 3'h1;
    settle();
    chk(1'b1, 8'h50, 4'h2, 1'b0);
    timer_compare_a <= 3'h0;
    timer_compare_b <= 3'h4;
    timer_overflow <= 3'h2;
    settle();
    chk(1'b1, 8'h59, 4'h4, 1'b0);
    timer_compare_b <= 3'h0;
    settle();
    chk(1'b1, 8'h56, 4'h1, 1'b0);
    timer_overflow <= 3'h0;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_nmi();
    t_brk();
    t_pin();
    t_chip();
    t_reset();
    complete_run();
  end

  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
endmodule
